// ==== rtl/csc_core.sv ====
/*
 * instruction execution for sleep, accumulator clear, complement,
 * decrement and watchdog kick, plus power-down control and pin hold.
 * assumes one instruction word presented per cycle with instr_valid, a
 * register file outside that returns file_rd_data combinationally for
 * file_addr, and a clock generator that stops while osc_run is low.
 */
`default_nettype none
`include "csc_map.svh"
module csc_core #(
    parameter int ADDR_W = 7,
    parameter int PINS = 16
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic wdt_enable,
    input wire logic wake_event,
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    input wire logic [7:0] file_rd_data,
    input wire logic [PINS-1:0] port_out_data,
    input wire logic [PINS-1:0] port_drive,
    output logic [ADDR_W-1:0] file_addr,
    output logic [7:0] file_wr_data,
    output logic file_wr_en,
    output logic [7:0] accumulator_reg,
    output logic result_null_flag,
    output logic timeout_flag,
    output logic power_down_flag,
    output logic power_down,
    output logic osc_run,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe_n,
    output logic [`CSC_WDT_W-1:0] wdt_count,
    output logic wdt_reset_req,
    output logic ext_reset_pin_oe_n
);
    csc_pkg::csc_state_t state_reg, state_next;
    logic [7:0] acc_next;
    logic z_reg, z_next;
    logic to_reg, to_next, pd_reg, pd_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0] wdata_reg;
    logic wen_reg;
    logic [PINS-1:0] pin_reg, oe_n_reg;
    logic osc_reg, wdr_reg;
    logic [7:0] acc_reg;
    logic wdt_timeout;
    logic [`CSC_WDT_W-1:0] wdt_cnt;

    function automatic csc_pkg::csc_op_t csc_decode(input logic [13:0] w);
        logic [5:0] hi;
        hi = w[`CSC_OP_HI_MSB:`CSC_OP_HI_LSB];
        if (w == `CSC_OP_CLRACC) csc_decode = csc_pkg::CSC_OP_CLRA;
        else if (w == `CSC_OP_KICK) csc_decode = csc_pkg::CSC_OP_KICK;
        else if (w == `CSC_OP_SLEEP) csc_decode = csc_pkg::CSC_OP_SLP;
        else if (hi == `CSC_OP_COMPL) csc_decode = csc_pkg::CSC_OP_COMPLEMENT_FILE_OP;
        else if (hi == `CSC_OP_DECR) csc_decode = csc_pkg::CSC_OP_DECR;
        else csc_decode = csc_pkg::CSC_OP_NONE;
    endfunction

    wire running = (state_reg == csc_pkg::CSC_RUN);
    wire csc_pkg::csc_op_t op = (instr_valid && running) ?
        csc_decode(instr_word) : csc_pkg::CSC_OP_NONE;
    wire dest_file = instr_word[`CSC_DEST_BIT];
    wire [ADDR_W-1:0] op_addr = instr_word[`CSC_ADDR_MSB:0];
    wire is_complement_file_op = (op == csc_pkg::CSC_OP_COMPLEMENT_FILE_OP);
    wire is_decrement_file_op = (op == csc_pkg::CSC_OP_DECR);
    wire is_file = is_complement_file_op || is_decrement_file_op;
    wire is_kick = (op == csc_pkg::CSC_OP_KICK);
    wire is_sleep = (op == csc_pkg::CSC_OP_SLP);
    wire [7:0] comp_res = ~file_rd_data;
    wire [7:0] decr_res = file_rd_data - 8'h01;
    wire [7:0] file_res = is_complement_file_op ? comp_res : decr_res;

    // file address follows the instruction so the read data is valid in the same cycle
    assign file_addr = op_addr;

    csc_watchdog #(
        .PRE_W(`CSC_PRE_W),
        .WDT_W(`CSC_WDT_W)
    ) u_wdt (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .wdt_enable(wdt_enable),
        .kick(is_kick || is_sleep),
        .count(wdt_cnt),
        .timeout(wdt_timeout)
    );

    always_comb begin
        state_next = state_reg;
        acc_next = acc_reg;
        z_next = z_reg;
        to_next = to_reg;
        pd_next = pd_reg;
        case (op)
            csc_pkg::CSC_OP_CLRA: begin
                acc_next = 8'h00;
                z_next = 1'b1;
            end
            csc_pkg::CSC_OP_COMPLEMENT_FILE_OP, csc_pkg::CSC_OP_DECR: begin
                if (!dest_file) begin
                    acc_next = file_res;
                end
                z_next = (file_res == 8'h00);
            end
            csc_pkg::CSC_OP_KICK: begin
                to_next = 1'b1;
                pd_next = 1'b1;
            end
            csc_pkg::CSC_OP_SLP: begin
                state_next = csc_pkg::CSC_DOWN;
                pd_next = 1'b0;
                to_next = 1'b1;
            end
            default: begin
            end
        endcase
        // watchdog timeout clears timeout_flag and leaves sleep; wake also leaves
        if (wdt_timeout) begin
            to_next = 1'b0;
            state_next = csc_pkg::CSC_RUN;
        end else if (wake_event && !running) begin
            state_next = csc_pkg::CSC_RUN;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= csc_pkg::CSC_RUN;
            acc_reg <= `CSC_RST_ACC;
            z_reg <= 1'b0;
            to_reg <= `CSC_RST_TO;
            pd_reg <= `CSC_RST_PD;
        end else begin
            state_reg <= state_next;
            acc_reg <= acc_next;
            z_reg <= z_next;
            to_reg <= to_next;
            pd_reg <= pd_next;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wdata_reg <= 8'h00;
            wen_reg <= 1'b0;
            addr_reg <= '0;
        end else begin
            wdata_reg <= file_res;
            wen_reg <= is_file && dest_file;
            addr_reg <= op_addr;
        end
    end

    // pins latch only while running; in power-down the last drive is held
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_reg <= '0;
            oe_n_reg <= '1;
        end else if (state_next == csc_pkg::CSC_RUN && running) begin
            pin_reg <= port_out_data;
            oe_n_reg <= ~port_drive;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_reg <= 1'b1;
            wdr_reg <= 1'b0;
        end else begin
            osc_reg <= (state_next == csc_pkg::CSC_RUN);
            wdr_reg <= wdt_timeout && running;
        end
    end

    assign file_wr_data = wdata_reg;
    assign file_wr_en = wen_reg;
    assign accumulator_reg = acc_reg;
    assign result_null_flag = z_reg;
    assign timeout_flag = to_reg;
    assign power_down_flag = pd_reg;
    assign power_down = state_reg;
    assign osc_run = osc_reg;
    assign pin_out = pin_reg;
    assign pin_oe_n = oe_n_reg;
    assign wdt_count = wdt_cnt;
    assign wdt_reset_req = wdr_reg;
    // the external reset pin is never driven; watchdog reset stays internal
    assign ext_reset_pin_oe_n = 1'b1;
endmodule
`default_nettype wire

// ==== rtl/csc_map.svh ====
/*
 * constants for the sleep and clear-op decoder: opcode patterns, field
 * positions, reset values and watchdog widths.
 * assumes a 14-bit instruction word and an 8-bit data path.
 */
// Functional notes
// - executing sleep puts the core into power-down.
// - entering power-down with watchdog enabled clears it; it keeps counting.
// - entering power-down clears power_down_flag and sets timeout_flag.
// - entering power-down switches the oscillator driver off, stopping the core clock.
// - during power-down every pin holds its prior drive: high, low or released.
// - a watchdog timeout resets internally only, never pulls the external reset pin.
// - accumulator_clear_op loads zero into accumulator and sets result_null_flag.
// - complement_file_op inverts the addressed register and updates result_null_flag.
// - destination bit 0 writes accumulator, 1 writes back the addressed register.
// - decrement_file_op subtracts one from addressed register, updates result_null_flag.
// - watchdog_kick_op clears the watchdog counter and its prescaler.
// - watchdog_kick_op sets timeout_flag and power_down_flag.
`ifndef CSC_MAP_SVH
`define CSC_MAP_SVH
`define CSC_OP_CLRACC 14'h0103
`define CSC_OP_KICK 14'h0064
`define CSC_OP_SLEEP 14'h0063
`define CSC_OP_HI_MSB 13
`define CSC_OP_HI_LSB 8
`define CSC_OP_COMPL 6'h09
`define CSC_OP_DECR 6'h03
`define CSC_DEST_BIT 7
`define CSC_ADDR_MSB 6
`define CSC_RST_ACC 8'h00
`define CSC_RST_TO 1'h1
`define CSC_RST_PD 1'h1
`define CSC_WDT_W 8
`define CSC_PRE_W 7
`endif

// ==== rtl/csc_pkg.sv ====
/*
 * types shared by the sleep and clear-op decoder.
 * assumes nothing beyond a systemverilog compiler.
 */
`default_nettype none
package csc_pkg;
    typedef enum logic [2:0] {
        CSC_OP_NONE = 3'b000,
        CSC_OP_CLRA = 3'b001,
        CSC_OP_COMPLEMENT_FILE_OP = 3'b010,
        CSC_OP_DECR = 3'b011,
        CSC_OP_KICK = 3'b100,
        CSC_OP_SLP = 3'b101
    } csc_op_t;
    typedef enum logic [0:0] {
        CSC_RUN = 1'b0,
        CSC_DOWN = 1'b1
    } csc_state_t;
endpackage
`default_nettype wire

// ==== rtl/csc_watchdog.sv ====
/*
 * watchdog counter with prescaler for the sleep and clear-op decoder.
 * assumes enable comes from configuration and kick from the decoder, same clock.
 */
`default_nettype none
`include "csc_map.svh"
module csc_watchdog #(
    parameter int PRE_W = `CSC_PRE_W,
    parameter int WDT_W = `CSC_WDT_W
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic wdt_enable,
    input wire logic kick,
    output logic [WDT_W-1:0] count,
    output logic timeout
);
    logic [PRE_W-1:0] pre_reg;
    logic [WDT_W-1:0] cnt_reg;
    logic to_reg;
    wire pre_wrap = &pre_reg;
    wire cnt_wrap = &cnt_reg;
    // kick clears both counter and prescaler, so a clear is never half done
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_reg <= '0;
            cnt_reg <= '0;
            to_reg <= 1'b0;
        end else if (kick || !wdt_enable) begin
            pre_reg <= '0;
            cnt_reg <= '0;
            to_reg <= 1'b0;
        end else begin
            pre_reg <= pre_pre_next(pre_reg);
            if (pre_wrap) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
            to_reg <= pre_wrap && cnt_wrap;
        end
    end
    function automatic logic [PRE_W-1:0] pre_pre_next(input logic [PRE_W-1:0] v);
        pre_pre_next = v + 1'b1;
    endfunction
    assign count = cnt_reg;
    assign timeout = to_reg;
endmodule
`default_nettype wire

// ==== sim/csc_core_chk.sv ====
/*
 * port checker for csc_core.
 * assumes it is bound onto csc_core and shares its clock and reset.
 */
`default_nettype none
`include "csc_map.svh"
module csc_chk #(
    parameter int PINS = 16
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic instr_valid,
    input wire logic [13:0] instr_word,
    input wire logic [7:0] file_rd_data,
    input wire logic [7:0] file_wr_data,
    input wire logic file_wr_en,
    input wire logic [7:0] accumulator_reg,
    input wire logic result_null_flag,
    input wire logic timeout_flag,
    input wire logic power_down_flag,
    input wire logic power_down,
    input wire logic osc_run,
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe_n,
    input wire logic [`CSC_WDT_W-1:0] wdt_count,
    input wire logic ext_reset_pin_oe_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // taken only while awake; sleeping cores ignore the word
    wire tk = instr_valid && !power_down;
    wire [5:0] hi = instr_word[13:8];
    wire dst = instr_word[`CSC_DEST_BIT];
    sequence s_slp; tk && instr_word == `CSC_OP_SLEEP; endsequence
    sequence s_com0; tk && hi == `CSC_OP_COMPL && !dst; endsequence
    sequence s_dec0; tk && hi == `CSC_OP_DECR && !dst; endsequence
    sequence s_dec1; tk && hi == `CSC_OP_DECR && dst; endsequence
    property p_sleep; s_slp |=> power_down && !power_down_flag && timeout_flag; endproperty
    property p_osc; s_slp |=> !osc_run && wdt_count == 8'h00; endproperty
    property p_hold;
        power_down && $past(power_down) |-> $stable(pin_out) && $stable(pin_oe_n);
    endproperty
    property p_ext; 1'b1 |-> ext_reset_pin_oe_n; endproperty
    property p_clra;
        tk && instr_word == `CSC_OP_CLRACC |=> accumulator_reg == 8'h00 && result_null_flag;
    endproperty
    property p_complement_file_op;
        s_com0 |=> accumulator_reg == ~$past(file_rd_data)
            && result_null_flag == ($past(file_rd_data) == 8'hFF);
    endproperty
    property p_decr;
        s_dec0 |=> accumulator_reg == $past(file_rd_data) - 8'h01
            && result_null_flag == ($past(file_rd_data) == 8'h01);
    endproperty
    property p_wb;
        s_dec1 |=> file_wr_en && file_wr_data == $past(file_rd_data) - 8'h01;
    endproperty
    property p_kick;
        tk && instr_word == `CSC_OP_KICK |=> timeout_flag && power_down_flag && wdt_count == 8'h00;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
    a_osc: assert property (p_osc) else $error("osc or watchdog wrong");
    a_hold: assert property (p_hold) else $error("pins moved asleep");
    a_ext: assert property (p_ext) else $error("reset pin driven");
    a_clra: assert property (p_clra) else $error("clear acc wrong");
    a_complement_file_op: assert property (p_complement_file_op) else $error("complement wrong");
    a_decr: assert property (p_decr) else $error("decrement wrong");
    a_wb: assert property (p_wb) else $error("write back wrong");
    a_kick: assert property (p_kick) else $error("kick wrong");
endmodule
bind csc_core csc_chk #(.PINS(PINS)) csc_chk_inst (.*);
`default_nettype wire

// ==== sim/tb_top.sv ====
/*
 * directed bench for csc_core.
 * assumes the checker file is compiled alongside.
 */
`default_nettype none
`include "csc_map.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, arst_n = 0, wdt_enable = 0, wake_event = 0, instr_valid = 0;
    logic [13:0] instr_word = 14'h0000;
    logic [7:0] file_rd_data = 8'h00;
    logic [15:0] port_out_data = 16'h0000, port_drive = 16'h0000;
    logic [6:0] file_addr;
    logic [7:0] file_wr_data, accumulator_reg, wdt_count;
    logic file_wr_en, result_null_flag, timeout_flag, power_down_flag, power_down, osc_run;
    logic [15:0] pin_out, pin_oe_n;
    logic wdt_reset_req, ext_reset_pin_oe_n;
    int err_count = 0, num_checks = 0, cycles = 0;
    csc_core csc_core_inst (.core_clk, .arst_n, .wdt_enable, .wake_event, .instr_valid,
        .instr_word, .file_rd_data, .port_out_data, .port_drive, .file_addr, .file_wr_data,
        .file_wr_en, .accumulator_reg, .result_null_flag, .timeout_flag, .power_down_flag,
        .power_down, .osc_run, .pin_out, .pin_oe_n, .wdt_count, .wdt_reset_req,
        .ext_reset_pin_oe_n);
    initial forever #50 core_clk = ~core_clk;
    // the whole run is near 620 cycles; the ceiling leaves wide margin
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            print_verdict();
        end
    end
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // called at a falling edge; valid stays up so back-to-back words need no gap,
    // the caller lowers it once the last word is taken
    task op(input logic [13:0] w, input logic [7:0] rd);
        instr_word = w;
        file_rd_data = rd;
        instr_valid = 1;
        @(negedge core_clk);
    endtask
    task t_alu;
        op(14'h0905, 8'h13);
        `CHK("acc", 8'hEC, accumulator_reg)
        `CHK("z", 1'b0, result_null_flag)
        `CHK("addr", 7'h05, file_addr)
        op(`CSC_OP_CLRACC, 8'h00);
        `CHK("acc", 8'h00, accumulator_reg)
        `CHK("z", 1'b1, result_null_flag)
        op(14'h0305, 8'h00);
        `CHK("acc", 8'hFF, accumulator_reg)
        `CHK("z", 1'b0, result_null_flag)
        op(14'h0385, 8'h01);
        `CHK("z", 1'b1, result_null_flag)
        `CHK("wr_en", 1'b1, file_wr_en)
        `CHK("wr_data", 8'h00, file_wr_data)
        `CHK("acc", 8'hFF, accumulator_reg)
        op(14'h0985, 8'h5A);
        instr_valid = 0;
        `CHK("wr_en", 1'b1, file_wr_en)
        `CHK("wr_data", 8'hA5, file_wr_data)
        `CHK("acc", 8'hFF, accumulator_reg)
        @(negedge core_clk);
        `CHK("wr_en", 1'b0, file_wr_en)
        $display("test alu done");
    endtask
    task t_sleep;
        wdt_enable = 1;
        port_out_data = 16'hA5C3;
        port_drive = 16'h0F0F;
        repeat (300) @(negedge core_clk);
        op(`CSC_OP_SLEEP, 8'h00);
        `CHK("power_down", 1'b1, power_down)
        `CHK("pd", 1'b0, power_down_flag)
        `CHK("to", 1'b1, timeout_flag)
        `CHK("osc_run", 1'b0, osc_run)
        `CHK("wdt", 8'h00, wdt_count)
        port_out_data = 16'h5A3C;
        port_drive = 16'hF0F0;
        op(`CSC_OP_CLRACC, 8'h00);
        instr_valid = 0;
        repeat (300) @(negedge core_clk);
        `CHK("oe_n", 16'hF0F0, pin_oe_n)
        `CHK("pins", 16'h0503, pin_out & 16'h0F0F)
        `CHK("acc", 8'hFF, accumulator_reg)
        `CHK("wdt runs", 1'b1, wdt_count != 8'h00)
        wake_event = 1;
        repeat (3) @(negedge core_clk);
        wake_event = 0;
        `CHK("awake", 1'b0, power_down)
        `CHK("osc_run", 1'b1, osc_run)
        op(`CSC_OP_KICK, 8'h00);
        instr_valid = 0;
        `CHK("wdt", 8'h00, wdt_count)
        `CHK("to", 1'b1, timeout_flag)
        `CHK("pd", 1'b1, power_down_flag)
        `CHK("ext", 1'b1, ext_reset_pin_oe_n)
        `CHK("wdt_req", 1'b0, wdt_reset_req)
        $display("test sleep done");
    endtask
    initial begin
        repeat (4) @(negedge core_clk);
        arst_n = 1;
        @(negedge core_clk);
        t_alu();
        t_sleep();
        print_verdict();
    end
endmodule
`default_nettype wire
